//--- ipm_pkg.sv
package ipm_pkg;
    localparam int unsigned NSRC = 10;
    localparam int unsigned SRC_W = 4;
    // Source index in polling order
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_BROWN = 4'h1;
    localparam logic [3:0] SRC_TMR0 = 4'h2;
    localparam logic [3:0] SRC_EXT1 = 4'h3;
    localparam logic [3:0] SRC_TMR1 = 4'h4;
    localparam logic [3:0] SRC_CARR = 4'h5;
    localparam logic [3:0] SRC_EXT2 = 4'h6;
    localparam logic [3:0] SRC_EXT3 = 4'h7;
    localparam logic [3:0] SRC_SER = 4'h8;
    localparam logic [3:0] SRC_TMR2 = 4'h9;
    // Vector addresses
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002b;
    localparam logic [15:0] VEC_CARR = 16'h0033;
    localparam logic [15:0] VEC_EXT2 = 16'h003b;
    localparam logic [15:0] VEC_EXT3 = 16'h0043;
    localparam logic [15:0] VEC_BROWN = 16'h004b;
    // Power control and extended enable register fields
    localparam int unsigned IDLE_BIT = 0;
    localparam int unsigned PDN_BIT = 1;
    localparam int unsigned EBO_BIT = 3;
    localparam logic [7:0] POWER_CONTROL_REGISTER_RST = 8'h00;
    // Wake-pin low time
    localparam int unsigned WAKE_LOW_CLKS = 1024;
    localparam logic [10:0] WAKE_CNT_MAX = 11'(WAKE_LOW_CLKS);
    localparam logic [15:0] VEC_RST = 16'h0000;
    typedef enum logic [1:0] {IPM_RUN, IPM_IDLE, IPM_PDOWN, IPM_WAKE} ipm_mode_e;
endpackage : ipm_pkg

//--- ipm_arbiter.sv
`timescale 1ns/10ps
module ipm_arbiter
    import ipm_pkg::*;
(
    // Requests and per-source priority pairs
    input  wire logic [ipm_pkg::NSRC-1:0] i_req,
    input  wire logic [ipm_pkg::NSRC-1:0] i_prio_lo,
    input  wire logic [ipm_pkg::NSRC-1:0] i_prio_hi,
    // Winner
    output logic                          o_valid,
    output logic [ipm_pkg::SRC_W-1:0]     o_src,
    output logic [1:0]                    o_level
);
    always_comb begin
        o_valid = 1'b0;
        o_src   = '0;
        o_level = '0;
        // Lowest index wins on ties; higher level always wins
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (i_req[i] && (!o_valid || {i_prio_hi[i], i_prio_lo[i]} >= o_level)) begin
                o_valid = 1'b1;
                o_src   = SRC_W'(i);
                o_level = {i_prio_hi[i], i_prio_lo[i]};
            end
        end
    end
endmodule : ipm_arbiter

//--- ipm_core.sv
`timescale 1ns/10ps
// Contract
// - Four priority levels from per-source bit pair
// - Fixed polling order among equal levels
// - Fixed vector address per source
// - Serial and SPI flags share one vector
// - Idle bit halts program counter only
// - Interrupt in idle clears idle bit
// - Hardware reset ends either low-power mode
// - Idle holds both strobes high
// - Power-down bit stops the clock
// - Power-down drives both strobes low
// - Power-down wakes on enabled level inputs only
// - Only external 0 and 1 wake
// - Wake pin low 1024 clocks arms wake; oscillator restarts when pin goes high
// - Pin high clears power-down, starts handler
// - Return resumes after power-down instruction
// - Brown-out enabled by extended enable bit 3
module ipm_core
    import ipm_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Source flags
    input  wire logic        i_ext0_request_flag,
    input  wire logic        i_ext1_request_flag,
    input  wire logic        i_ext2_request_flag,
    input  wire logic        i_ext3_request_flag,
    input  wire logic        i_timer0_overflow_flag,
    input  wire logic        i_timer1_overflow_flag,
    input  wire logic        i_timer2_overflow_flag,
    input  wire logic        i_timer2_external_flag,
    input  wire logic        i_counter_array_overflow_flag,
    input  wire logic [4:0]  i_counter_module_flag,
    input  wire logic        i_serial_tx_done_flag,
    input  wire logic        i_serial_rx_done_flag,
    input  wire logic        i_spi_done_flag,
    input  wire logic        i_brownout,
    // External pins, active low, asynchronous
    input  wire logic        i_ext0_pin_n,
    input  wire logic        i_ext1_pin_n,
    input  wire logic        i_ext0_edge_mode,
    input  wire logic        i_ext1_edge_mode,
    // Enables and priorities, polling order index
    input  wire logic [ipm_pkg::NSRC-1:0] i_enable,
    input  wire logic        i_global_enable,
    input  wire logic [ipm_pkg::NSRC-1:0] i_prio_lo,
    input  wire logic [ipm_pkg::NSRC-1:0] i_prio_hi,
    // Power control and extended enable writes
    input  wire logic        i_power_control_register_we,
    input  wire logic [7:0]  i_power_control_register_wdata,
    input  wire logic        i_iea_we,
    input  wire logic [7:0]  i_iea_wdata,
    // Core handshake
    input  wire logic        i_core_pc,
    input  wire logic [15:0] i_next_pc,
    input  wire logic        i_ack,
    input  wire logic        i_return_from_interrupt,
    // To core
    output logic             o_irq,
    output logic [15:0]      o_vector,
    output logic             o_pc_halt,
    output logic             o_clk_stop,
    output logic             o_brownout_reset,
    output logic [7:0]       o_power_control_register,
    output logic             o_brownout_irq_enable,
    output logic [15:0]      o_resume_pc,
    output logic             o_ale,
    output logic             o_program_store_strobe_n,
    output logic [1:0]       o_mode
);
    import ipm_pkg::*;

    logic [NSRC-1:0] req;
    logic            arb_valid;
    logic [SRC_W-1:0] arb_src;
    logic [1:0]      arb_level;
    logic [1:0]      s0_r, s1_r;
    logic            ext0_lo, ext1_lo;
    ipm_mode_e       mode_r, mode_nxt;
    logic [7:0]      power_control_register_r, power_control_register_nxt;
    logic            ebo_r, ebo_nxt;
    logic [10:0]     wcnt_r, wcnt_nxt;
    logic [3:0]      active_r, active_nxt;
    logic            irq_r, irq_nxt;
    logic [1:0]      lvl_r, lvl_nxt;
    logic [15:0]     vec_r, vec_nxt;
    logic [15:0]     resume_r, resume_nxt;
    logic            bor_r, bor_nxt;
    logic            wake_ok;

    function automatic logic [15:0] vec_of(input logic [SRC_W-1:0] s);
        unique case (s)
            SRC_EXT0:  vec_of = VEC_EXT0;
            SRC_BROWN: vec_of = VEC_BROWN;
            SRC_TMR0:  vec_of = VEC_TMR0;
            SRC_EXT1:  vec_of = VEC_EXT1;
            SRC_TMR1:  vec_of = VEC_TMR1;
            SRC_CARR:  vec_of = VEC_CARR;
            SRC_EXT2:  vec_of = VEC_EXT2;
            SRC_EXT3:  vec_of = VEC_EXT3;
            SRC_SER:   vec_of = VEC_SER;
            SRC_TMR2:  vec_of = VEC_TMR2;
            default:   vec_of = VEC_RST;
        endcase
    endfunction : vec_of

    // Pin synchroniser
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s0_r <= 2'h3;
            s1_r <= 2'h3;
        end else begin
            s0_r <= {i_ext1_pin_n, i_ext0_pin_n};
            s1_r <= s0_r;
        end
    end
    assign ext0_lo = !s1_r[0];
    assign ext1_lo = !s1_r[1];

    always_comb begin
        req = '0;
        req[SRC_EXT0]  = i_ext0_request_flag;
        req[SRC_BROWN] = i_brownout && ebo_r;
        req[SRC_TMR0]  = i_timer0_overflow_flag;
        req[SRC_EXT1]  = i_ext1_request_flag;
        req[SRC_TMR1]  = i_timer1_overflow_flag;
        req[SRC_CARR]  = i_counter_array_overflow_flag || (|i_counter_module_flag);
        req[SRC_EXT2]  = i_ext2_request_flag;
        req[SRC_EXT3]  = i_ext3_request_flag;
        req[SRC_SER]   = i_serial_tx_done_flag || i_serial_rx_done_flag || i_spi_done_flag;
        req[SRC_TMR2]  = i_timer2_overflow_flag || i_timer2_external_flag;
        req = req & i_enable & {NSRC{i_global_enable}};
    end

    ipm_arbiter u_arb (
        .i_req     (req),
        .i_prio_lo (i_prio_lo),
        .i_prio_hi (i_prio_hi),
        .o_valid   (arb_valid),
        .o_src     (arb_src),
        .o_level   (arb_level)
    );

    // Level-sensitive enabled wake pins, ext0 and ext1 only
    assign wake_ok = i_global_enable &&
                     ((i_enable[SRC_EXT0] && !i_ext0_edge_mode && ext0_lo) ||
                      (i_enable[SRC_EXT1] && !i_ext1_edge_mode && ext1_lo));

    always_comb begin
        mode_nxt   = mode_r;
        power_control_register_nxt   = power_control_register_r;
        ebo_nxt    = ebo_r;
        wcnt_nxt   = wcnt_r;
        active_nxt = active_r;
        irq_nxt    = 1'b0;
        lvl_nxt    = lvl_r;
        vec_nxt    = vec_r;
        resume_nxt = resume_r;
        bor_nxt    = i_brownout && !ebo_r;
        if (i_iea_we) begin
            ebo_nxt = i_iea_wdata[EBO_BIT];
        end
        if (i_return_from_interrupt) begin
            // Drop the highest active level
            if (active_r[3]) active_nxt[3] = 1'b0;
            else if (active_r[2]) active_nxt[2] = 1'b0;
            else if (active_r[1]) active_nxt[1] = 1'b0;
            else active_nxt[0] = 1'b0;
        end
        unique case (mode_r)
            IPM_RUN: begin
                if (i_power_control_register_we) begin
                    power_control_register_nxt   = i_power_control_register_wdata;
                    resume_nxt = i_next_pc;
                    if (i_power_control_register_wdata[PDN_BIT]) mode_nxt = IPM_PDOWN;
                    else if (i_power_control_register_wdata[IDLE_BIT]) mode_nxt = IPM_IDLE;
                end
            end
            IPM_IDLE: begin
                if (irq_r && i_ack) begin
                    power_control_register_nxt[IDLE_BIT] = 1'b0;
                    mode_nxt = IPM_RUN;
                end
            end
            IPM_PDOWN: begin
                if (wake_ok) begin
                    wcnt_nxt = (wcnt_r == WAKE_CNT_MAX) ? wcnt_r : wcnt_r + 11'h001;
                end else if (wcnt_r == WAKE_CNT_MAX) begin
                    mode_nxt = IPM_WAKE;
                    wcnt_nxt = '0;
                end else begin
                    wcnt_nxt = '0;
                end
            end
            IPM_WAKE: begin
                if (irq_r && i_ack) begin
                    power_control_register_nxt[PDN_BIT] = 1'b0;
                    mode_nxt = IPM_RUN;
                end
            end
        endcase
        if (mode_r != IPM_PDOWN && arb_valid && !irq_r &&
            (active_r >> arb_level) == 4'h0 && !(i_ack && irq_r)) begin
            irq_nxt = 1'b1;
            // Keep the offered level; the arbiter may pick another before the ack
            lvl_nxt = arb_level;
            vec_nxt = vec_of(arb_src);
        end
        if (irq_r && !i_ack) begin
            irq_nxt = 1'b1;
        end
        if (irq_r && i_ack) begin
            active_nxt[lvl_r] = 1'b1;
            irq_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_r   <= IPM_RUN;
            power_control_register_r   <= POWER_CONTROL_REGISTER_RST;
            ebo_r    <= 1'b0;
            wcnt_r   <= '0;
            active_r <= '0;
            irq_r    <= 1'b0;
            lvl_r    <= 2'h0;
            vec_r    <= VEC_RST;
            resume_r <= VEC_RST;
            bor_r    <= 1'b0;
            o_ale    <= 1'b1;
            o_program_store_strobe_n <= 1'b1;
            o_pc_halt  <= 1'b0;
            o_clk_stop <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            power_control_register_r   <= power_control_register_nxt;
            ebo_r    <= ebo_nxt;
            wcnt_r   <= wcnt_nxt;
            active_r <= active_nxt;
            irq_r    <= irq_nxt;
            lvl_r    <= lvl_nxt;
            vec_r    <= vec_nxt;
            resume_r <= resume_nxt;
            bor_r    <= bor_nxt;
            o_ale    <= (mode_nxt != IPM_PDOWN) && (mode_nxt != IPM_WAKE || i_core_pc);
            o_program_store_strobe_n <= (mode_nxt != IPM_PDOWN);
            o_pc_halt  <= (mode_nxt != IPM_RUN);
            o_clk_stop <= (mode_nxt == IPM_PDOWN);
        end
    end

    assign o_irq    = irq_r;
    assign o_vector = vec_r;
    assign o_brownout_reset = bor_r;
    assign o_power_control_register = power_control_register_r;
    assign o_brownout_irq_enable = ebo_r;
    assign o_resume_pc = resume_r;
    assign o_mode = mode_r;
endmodule : ipm_core

//--- ipm_core_monitor.sv
`timescale 1ns/10ps
module ipm_core_monitor (
    // Clock, reset and stimulus
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_ext0_pin_n,
    input wire logic        i_ext1_pin_n,
    input wire logic        i_power_control_register_we,
    input wire logic [7:0]  i_power_control_register_wdata,
    input wire logic        i_ack,
    input wire logic        i_brownout,
    // Block outputs
    input wire logic        o_irq,
    input wire logic [15:0] o_vector,
    input wire logic        o_clk_stop,
    input wire logic        o_brownout_reset,
    input wire logic [7:0]  o_power_control_register,
    input wire logic        o_brownout_irq_enable,
    input wire logic        o_ale,
    input wire logic        o_program_store_strobe_n,
    input wire logic [1:0]  o_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence taken_s; o_irq && i_ack; endsequence
    sequence quiet_s; (i_ext0_pin_n && i_ext1_pin_n) [*8]; endsequence
    a_offer_stands: assert property (o_irq && !i_ack |=> o_irq && $stable(o_vector))
        else $error("offer withdrawn early");
    a_offer_drops: assert property (taken_s |=> !o_irq)
        else $error("offer kept after ack");
    a_pd_entry: assert property (o_mode == 2'h0 && i_power_control_register_we && i_power_control_register_wdata[1]
        |=> o_mode == 2'h2 && o_clk_stop) else $error("power-down not entered");
    a_idle_state: assert property (o_mode == 2'h1
        |-> o_ale && o_program_store_strobe_n && !o_clk_stop) else $error("bad idle state");
    a_pd_state: assert property (o_mode == 2'h2
        |-> !o_ale && !o_program_store_strobe_n && o_clk_stop && !o_irq)
        else $error("bad power-down state");
    a_idle_exit: assert property (o_mode == 2'h1 ##0 taken_s
        |=> o_mode == 2'h0 && !o_power_control_register[0]) else $error("idle not left");
    a_wake_exit: assert property (o_mode == 2'h3 ##0 taken_s
        |=> o_mode == 2'h0 && !o_power_control_register[1]) else $error("wake not done");
    a_pd_hold: assert property (quiet_s ##0 o_mode == 2'h2 |=> o_mode == 2'h2)
        else $error("woke without pin");
    a_bo_reset: assert property (i_brownout && !o_brownout_irq_enable
        |-> ##[1:3] o_brownout_reset) else $error("brown-out reset missing");
endmodule : ipm_core_monitor

bind ipm_core ipm_core_monitor u_mon (
    .i_clk, .i_reset_n, .i_ext0_pin_n, .i_ext1_pin_n, .i_power_control_register_we, .i_power_control_register_wdata, .i_ack,
    .i_brownout, .o_irq, .o_vector, .o_clk_stop, .o_brownout_reset, .o_power_control_register,
    .o_brownout_irq_enable, .o_ale, .o_program_store_strobe_n, .o_mode
);

//--- ipm_core_model.sv
`timescale 1ns/10ps
module ipm_core_model (
    // Clock, reset and offer
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_irq,
    input  wire logic i_slow,
    // Acknowledge pulse
    output logic      o_ack
);
    logic [2:0] wait_r;
    // Takes an offer one or four cycles after seeing it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_r <= 3'h0;
            o_ack  <= 1'b0;
        end else if (o_ack || !i_irq) begin
            wait_r <= 3'h0;
            o_ack  <= 1'b0;
        end else begin
            wait_r <= wait_r + 3'h1;
            o_ack  <= wait_r >= (i_slow ? 3'h3 : 3'h0);
        end
    end
endmodule : ipm_core_model

//--- test_ipm_core.sv
`timescale 1ns/10ps
module test_ipm_core;
    import ipm_pkg::*;
    localparam logic [15:0] VT [18] = '{16'h0003, 16'h004b, 16'h000b, 16'h0013, 16'h001b,
        16'h0033, 16'h003b, 16'h0043, 16'h0023, 16'h002b, 16'h0023, 16'h0023, 16'h002b,
        16'h0033, 16'h0033, 16'h0033, 16'h0033, 16'h0033};
    logic        i_clk, i_reset_n, i_ack, i_return_from_interrupt, i_core_pc, i_global_enable;
    logic        i_ext0_request_flag, i_ext1_request_flag, i_ext2_request_flag;
    logic        i_ext3_request_flag, i_timer0_overflow_flag, i_timer1_overflow_flag;
    logic        i_timer2_overflow_flag, i_timer2_external_flag, i_counter_array_overflow_flag;
    logic        i_serial_tx_done_flag, i_serial_rx_done_flag, i_spi_done_flag, i_brownout;
    logic        i_ext0_pin_n, i_ext1_pin_n, i_ext0_edge_mode, i_ext1_edge_mode, slow;
    logic        i_power_control_register_we, i_iea_we, o_irq, o_pc_halt, o_clk_stop, o_brownout_reset;
    logic        o_brownout_irq_enable, o_ale, o_program_store_strobe_n;
    logic [1:0]  o_mode;
    logic [4:0]  i_counter_module_flag;
    logic [7:0]  i_power_control_register_wdata, i_iea_wdata, o_power_control_register;
    logic [9:0]  i_enable, i_prio_lo, i_prio_hi;
    logic [15:0] i_next_pc, o_vector, o_resume_pc;
    logic [17:0] flg;
    int          checked, miscompares;
    assign {i_counter_module_flag, i_timer2_external_flag, i_spi_done_flag, i_serial_rx_done_flag,
            i_timer2_overflow_flag, i_serial_tx_done_flag, i_ext3_request_flag, i_ext2_request_flag,
            i_counter_array_overflow_flag, i_timer1_overflow_flag, i_ext1_request_flag,
            i_timer0_overflow_flag, i_brownout, i_ext0_request_flag} = flg;
    always #2 i_clk = ~i_clk;
    ipm_core uut (.*);
    ipm_core_model peer (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_irq(o_irq), .i_slow(slow),
        .o_ack(i_ack));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic rti;
        @(posedge i_clk) i_return_from_interrupt <= 1'b1;
        @(posedge i_clk) i_return_from_interrupt <= 1'b0;
        @(negedge i_clk);
    endtask : rti
    // Waits for the core to take the offer, then drops that source's flag
    task automatic take(input int b, input bit r);
        int n;
        n = 0;
        while (i_ack !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        check("vector", o_vector, VT[b]);
        @(posedge i_clk) flg[b] <= 1'b0;
        @(negedge i_clk);
        check("offer", o_irq, 1'b0);
        if (r) rti();
    endtask : take
    task automatic wr(input bit s, input logic [7:0] d);
        @(posedge i_clk);
        {i_iea_we, i_power_control_register_we} <= {s, !s};
        {i_iea_wdata, i_power_control_register_wdata, i_next_pc} <= {d, d, d, 8'h5a};
        @(posedge i_clk) {i_iea_we, i_power_control_register_we} <= 2'h0;
        @(negedge i_clk);
    endtask : wr
    task automatic t_order;
        wr(1, 8'h08);
        check("bo_en", o_brownout_irq_enable, 1'b1);
        @(posedge i_clk) flg[9:0] <= 10'h3ff;
        for (int b = 0; b < 18; b++) begin
            if (b > 9) @(posedge i_clk) flg[b] <= 1'b1;
            take(b, 1);
        end
    endtask : t_order
    task automatic t_level;
        @(posedge i_clk);
        {slow, i_prio_hi, i_prio_lo} <= {1'b1, 20'h82210};
        flg[9:0] <= 10'h21c;
        take(9, 1);
        take(3, 1);
        take(4, 1);
        take(2, 1);
        @(posedge i_clk) flg[0] <= 1'b1;
        take(0, 0);
        @(posedge i_clk) flg[4] <= 1'b1;
        take(4, 1);
        rti();
        @(posedge i_clk) {slow, i_prio_hi, i_prio_lo} <= 21'h0;
    endtask : t_level
    task automatic t_idle;
        wr(0, 8'h01);
        check("idle", {o_mode, o_pc_halt, o_clk_stop}, 4'h6);
        check("strobe", {o_ale, o_program_store_strobe_n}, 2'h3);
        @(posedge i_clk) flg[5] <= 1'b1;
        take(5, 0);
        check("power_control_register", o_power_control_register, 8'h00);
        rti();
        check("resume", o_resume_pc, 16'h015a);
    endtask : t_idle
    task automatic t_pd;
        @(posedge i_clk) i_ext1_edge_mode <= 1'b1;
        wr(0, 8'h02);
        check("clk_stop", o_clk_stop, 1'b1);
        check("strobe", {o_ale, o_program_store_strobe_n}, 2'h0);
        @(posedge i_clk) {flg[2], flg[1], i_ext1_pin_n} <= 3'b110;
        cyc(1100);
        @(negedge i_clk);
        check("asleep", {o_mode, o_irq}, 3'h4);
        // A level-configured pin also raises its request flag while it is low
        @(posedge i_clk) {flg[2], flg[1], flg[0], i_ext1_pin_n, i_ext0_pin_n} <= 5'b00110;
        cyc(1040);
        i_ext0_pin_n <= 1'b1;
        take(0, 0);
        check("power_control_register", o_power_control_register, 8'h00);
        rti();
        check("resume", o_resume_pc, 16'h025a);
        @(posedge i_clk) i_ext1_edge_mode <= 1'b0;
    endtask : t_pd
    task automatic t_reset;
        wr(0, 8'h02);
        @(posedge i_clk) i_reset_n <= 1'b0;
        @(posedge i_clk) i_reset_n <= 1'b1;
        @(negedge i_clk);
        check("restart", {o_mode, o_clk_stop, o_ale, o_program_store_strobe_n,
            o_power_control_register}, 13'h0300);
        wr(1, 8'h00);
        @(posedge i_clk) flg[1] <= 1'b1;
        cyc(3);
        @(negedge i_clk);
        check("bo_reset", {o_brownout_reset, o_irq}, 2'h2);
        @(posedge i_clk) flg[1] <= 1'b0;
    endtask : t_reset
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {i_clk, i_reset_n, i_return_from_interrupt, i_power_control_register_we, i_iea_we, slow, flg} = '0;
        {i_ext0_edge_mode, i_ext1_edge_mode, i_prio_lo, i_prio_hi, i_next_pc} = '0;
        {i_ext0_pin_n, i_ext1_pin_n, i_core_pc, i_global_enable, i_enable} = '1;
        {i_power_control_register_wdata, i_iea_wdata, checked, miscompares} = '0;
        cyc(12);
        i_reset_n <= 1'b1;
        t_order();
        t_level();
        t_idle();
        t_pd();
        t_reset();
        report_and_stop();
    end
    initial begin
        cyc(20000);
        miscompares++;
        report_and_stop();
    end
endmodule : test_ipm_core
